// file: hdl/cluster_control_signal_gen.v
`timescale 1ns/100ps
`default_nettype none
`include "cluster_map.vh"
module cluster_control_signal_gen #(
	parameter NELEM = `CL_NUM_ELEM
) (
	input wire clk,
	input wire rst_n,
	input wire [3:0] columnClock,
	input wire [1:0] clockOneSel,
	input wire [1:0] clockTwoSel,
	input wire clockTwoInvert,
	input wire localClockEnableOne,
	input wire localClockEnableTwo,
	input wire localAsyncClearOne,
	input wire localAsyncClearTwo,
	input wire localAsyncLoad,
	input wire localSyncClear,
	input wire localSyncLoad,
	input wire localAddSub,
	input wire arithMode,
	input wire [NELEM-1:0] clockSelect,
	input wire [NELEM-1:0] clearSelect,
	input wire [NELEM-1:0] asyncLoadData,
	input wire [NELEM-1:0] syncLoadData,
	input wire [NELEM*4-1:0] lutData,
	input wire [NELEM*16-1:0] lutMask,
	input wire [NELEM-1:0] useLutChain,
	input wire [NELEM-1:0] useRegChain,
	input wire [NELEM-1:0] operandA,
	input wire [NELEM-1:0] operandB,
	input wire regChainHead,
	output reg [NELEM-1:0] lutOut_r,
	output reg [NELEM-1:0] regOut_r,
	output reg carryOut_r,
	output reg regChainOut_r,
	output reg [`CL_MAX_CTRL-1:0] ctrlBus_r
);
	// Three-stage synchronisers for column clocks and local controls
	localparam SW = 13;
	wire [SW-1:0] rawIn;
	reg [SW-1:0] syncA_r;
	reg [SW-1:0] syncB_r;
	reg [SW-1:0] syncC_r;
	reg [SW-1:0] stable_r;
	reg [SW-1:0] stable_nxt;
	assign rawIn = {localAddSub, localSyncLoad, localSyncClear, localAsyncLoad,
		localAsyncClearTwo, localAsyncClearOne, localClockEnableTwo,
		localClockEnableOne, 1'h0, columnClock};
	// Change accepted only when stages two and three agree
	always @* begin
		stable_nxt = stable_r;
		if (syncB_r == syncC_r)
			stable_nxt = syncC_r;
	end
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			syncA_r <= {SW{1'h0}};
			syncB_r <= {SW{1'h0}};
			syncC_r <= {SW{1'h0}};
			stable_r <= {SW{1'h0}};
		end else begin
			syncA_r <= rawIn;
			syncB_r <= syncA_r;
			syncC_r <= syncB_r;
			stable_r <= stable_nxt;
		end
	end
	wire [3:0] colClk;
	wire enaOne, enaTwo, aclrOne, aclrTwo, aload, sclr, sload, addSub;
	assign colClk = stable_r[3:0];
	assign {addSub, sload, sclr, aload, aclrTwo, aclrOne, enaTwo, enaOne} = stable_r[12:5];
	// Cluster clocks picked from column lines; edges sampled as ticks
	wire clkOneLvl, clkTwoLvl;
	reg clkOnePrev_r, clkTwoPrev_r;
	assign clkOneLvl = colClk[clockOneSel];
	assign clkTwoLvl = colClk[clockTwoSel] ^ clockTwoInvert;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clkOnePrev_r <= 1'h0;
			clkTwoPrev_r <= 1'h0;
		end else begin
			clkOnePrev_r <= clkOneLvl;
			clkTwoPrev_r <= clkTwoLvl;
		end
	end
	wire tickOne, tickTwo;
	// Enable gates the tick itself, so a disabled clock never fires
	assign tickOne = clkOneLvl & ~clkOnePrev_r & enaOne;
	assign tickTwo = clkTwoLvl & ~clkTwoPrev_r & enaTwo;
	// Element array with carry, table and register chains
	wire [NELEM:0] carry;
	wire [NELEM:0] lutChain;
	wire [NELEM:0] regChain;
	wire [NELEM-1:0] lutW;
	wire [NELEM-1:0] regW;
	assign carry[0] = addSub ? `CL_SUB_CIN : `CL_ADD_CIN;
	assign lutChain[0] = 1'h0;
	assign regChain[0] = regChainHead;
	genvar i;
	generate
		for (i = 0; i < NELEM; i = i + 1) begin : gElem
			logic_element uElem (
				.clk(clk),
				.rst_n(rst_n),
				.lutData(lutData[i*4 +: 4]),
				.lutMask(lutMask[i*16 +: 16]),
				.lutChainIn(lutChain[i]),
				.useLutChain(useLutChain[i]),
				.opA(operandA[i]),
				.opB(operandB[i]),
				.carryIn(carry[i]),
				.addSub(addSub & arithMode),
				.arithMode(arithMode),
				.edgeTick(clockSelect[i] ? tickTwo : tickOne),
				.clkEnable(clockSelect[i] ? enaTwo : enaOne),
				.asyncClear(clearSelect[i] ? aclrTwo : aclrOne),
				.asyncLoad(aload),
				.asyncData(asyncLoadData[i]),
				.syncClear(sclr),
				.syncLoad(sload),
				.syncData(syncLoadData[i]),
				.regChainIn(regChain[i]),
				.useRegChain(useRegChain[i]),
				.lutOut(lutW[i]),
				.carryOut(carry[i+1]),
				.regQ_r(regW[i])
			);
			assign lutChain[i+1] = lutW[i];
			assign regChain[i+1] = regW[i];
		end
	endgenerate
	// Outputs registered; control bus shows the eight live controls and both clock ticks
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lutOut_r <= {NELEM{1'h0}};
			regOut_r <= {NELEM{1'h0}};
			carryOut_r <= 1'h0;
			regChainOut_r <= 1'h0;
			ctrlBus_r <= {`CL_MAX_CTRL{1'h0}};
		end else begin
			lutOut_r <= lutW;
			regOut_r <= regW;
			carryOut_r <= carry[NELEM];
			regChainOut_r <= regChain[NELEM];
			ctrlBus_r <= {addSub, sload, aload, sclr, aclrTwo, aclrOne,
				enaTwo, enaOne, tickTwo, tickOne};
		end
	end
endmodule
`default_nettype wire

// file: hdl/cluster_map.vh
`ifndef CLUSTER_MAP_VH
`define CLUSTER_MAP_VH
// Cluster geometry and fixed codes
`define CL_NUM_ELEM 10
`define CL_NUM_COLCLK 4
`define CL_SEL_W 2
`define CL_MAX_CTRL 10
// Source select for local-interconnect controls
`define CL_LOCAL_SEL 2'h0
// Register reset value
`define CL_REG_RST 1'h0
// Carry-in forced on subtract
`define CL_SUB_CIN 1'h1
`define CL_ADD_CIN 1'h0
`endif

// file: hdl/logic_element.v
`timescale 1ns/100ps
`default_nettype none
// One element: table, adder bit and a register with cluster controls
module logic_element (
	input wire clk,
	input wire rst_n,
	input wire [3:0] lutData,
	input wire [15:0] lutMask,
	input wire lutChainIn,
	input wire useLutChain,
	input wire opA,
	input wire opB,
	input wire carryIn,
	input wire addSub,
	input wire arithMode,
	input wire edgeTick,
	input wire clkEnable,
	input wire asyncClear,
	input wire asyncLoad,
	input wire asyncData,
	input wire syncClear,
	input wire syncLoad,
	input wire syncData,
	input wire regChainIn,
	input wire useRegChain,
	output wire lutOut,
	output wire carryOut,
	output reg regQ_r
);
	wire [3:0] lutIdx;
	wire lutRaw;
	wire bEff;
	wire sumBit;
	wire dataIn;
	reg regQ_nxt;
	// Chain input replaces the first table input for wide cascades
	assign lutIdx = {lutData[3:1], useLutChain ? lutChainIn : lutData[0]};
	assign lutRaw = lutMask[lutIdx];
	// Operand inverted for subtract; cin forced at cluster head
	assign bEff = opB ^ addSub;
	assign sumBit = opA ^ bEff ^ carryIn;
	assign carryOut = (opA & bEff) | (carryIn & (opA ^ bEff));
	assign lutOut = arithMode ? sumBit : lutRaw;
	// Chain feeds register independent of the table result
	assign dataIn = useRegChain ? regChainIn : lutOut;
	// Synchronous priority: clear, then load, then data
	always @* begin
		regQ_nxt = regQ_r;
		if (clkEnable) begin
			if (syncClear)
				regQ_nxt = `CL_REG_RST;
			else if (syncLoad)
				regQ_nxt = syncData;
			else
				regQ_nxt = dataIn;
		end
	end
	// Async controls sampled as levels; clear beats load beats clocked path
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			regQ_r <= `CL_REG_RST;
		end else begin
			if (asyncClear)
				regQ_r <= `CL_REG_RST;
			else if (asyncLoad)
				regQ_r <= asyncData;
			else if (edgeTick)
				regQ_r <= regQ_nxt;
		end
	end
endmodule
`default_nettype wire

// file: testbench/cluster_ctrl_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module cluster_ctrl_monitor #(parameter NELEM = 10) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic localAddSub,
	input wire logic localAsyncLoad,
	input wire logic localAsyncClearOne,
	input wire logic localClockEnableOne,
	input wire logic [NELEM-1:0] clearSelect,
	input wire logic [NELEM-1:0] regOut_r,
	input wire logic [9:0] ctrlBus_r
);
	// Syncing delays inputs by a few edges, so follow checks use short windows
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	tick_needs_ena_a: assert property (ctrlBus_r[0] |-> ctrlBus_r[2]) else $error("tick1 no ena");
	tick_one_shot_a: assert property (ctrlBus_r[0] |=> !ctrlBus_r[0]) else $error("tick1 held");
	reset_quiet_a: assert property ($rose(rst_n) |-> ctrlBus_r == 10'h000) else $error("ctrl live");
	addsub_follow_a: assert property ($rose(localAddSub) |-> ##[1:5] ctrlBus_r[9]) else $error("addsub");
	aload_follow_a: assert property ($rose(localAsyncLoad) |-> ##[1:5] ctrlBus_r[7]) else $error("aload");
	aclr_follow_a: assert property ($rose(localAsyncClearOne) |-> ##[1:5] ctrlBus_r[4]) else $error("aclr");
	ena_follow_a: assert property ($fell(localClockEnableOne) |-> ##[1:5] !ctrlBus_r[2]) else $error("ena");
	clear_wins_a: assert property (ctrlBus_r[4] && !clearSelect[0] |-> ##[1:3] !regOut_r[0])
		else $error("clear lost");
endmodule
bind cluster_control_signal_gen cluster_ctrl_monitor #(.NELEM(NELEM)) mon (.clk(clk), .rst_n(rst_n),
	.localAddSub(localAddSub), .localAsyncLoad(localAsyncLoad), .localAsyncClearOne(localAsyncClearOne),
	.localClockEnableOne(localClockEnableOne), .clearSelect(clearSelect), .regOut_r(regOut_r),
	.ctrlBus_r(ctrlBus_r));
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	reg clk = 1'b0;
	reg rst_n = 1'b0;
	reg [3:0] colClk = 4'h0;
	reg enaOne = 1'b1, clrOne = 1'b0, aLoad = 1'b0, addSub = 1'b0, arith = 1'b0, head = 1'b0;
	reg [9:0] opA = 10'h2a5, opB = 10'h0f3;
	wire [9:0] lutQ, regQ, ctrl;
	wire carry, chainOut;
	// Static configuration held in regs so scenarios can move it
	reg [1:0] selOne = 2'h0, selTwo = 2'h1;
	reg invTwo = 1'b0, enaTwo = 1'b0, clrTwo = 1'b0, sClr = 1'b0, sLoad = 1'b0;
	reg [9:0] clkSel = 10'h000, clrSel = 10'h000, aData = 10'h3ff, sData = 10'h000;
	reg [9:0] lChain = 10'h000, rChain = 10'h3ff;
	reg [39:0] lData = 40'h0;
	reg [159:0] lMask = 160'h0;
	integer errCount = 0;
	integer samplesChecked = 0;
	// Whole cluster on clock one, all registers chained
	cluster_control_signal_gen dut (.clk(clk), .rst_n(rst_n), .columnClock(colClk),
		.clockOneSel(selOne), .clockTwoSel(selTwo), .clockTwoInvert(invTwo),
		.localClockEnableOne(enaOne), .localClockEnableTwo(enaTwo), .localAsyncClearOne(clrOne),
		.localAsyncClearTwo(clrTwo), .localAsyncLoad(aLoad), .localSyncClear(sClr),
		.localSyncLoad(sLoad), .localAddSub(addSub), .arithMode(arith), .clockSelect(clkSel),
		.clearSelect(clrSel), .asyncLoadData(aData), .syncLoadData(sData),
		.lutData(lData), .lutMask(lMask), .useLutChain(lChain), .useRegChain(rChain),
		.operandA(opA), .operandB(opB), .regChainHead(head), .lutOut_r(lutQ),
		.regOut_r(regQ), .carryOut_r(carry), .regChainOut_r(chainOut), .ctrlBus_r(ctrl));
	initial begin
		forever #5 clk = ~clk;
	end
	task w(input integer n);
		repeat (n) @(posedge clk);
	endtask
	task chk(input [10:0] exp, input [10:0] got);
		begin
			samplesChecked = samplesChecked + 1;
			if (got !== exp) begin
				errCount = errCount + 1;
				$display("Error t=%0t exp=%h got=%h", $time, exp, got);
			end
		end
	endtask
	// One column-clock period; long halves let the sync stages settle
	task pulse(input b);
		begin
			head <= b;
			colClk <= 4'h1;
			w(6);
			colClk <= 4'h0;
			w(6);
		end
	endtask
	task test_preset;
		begin
			aLoad <= 1'b1;
			w(8);
			chk(11'h3ff, {1'b0, regQ});
			clrOne <= 1'b1;
			w(8);
			chk(11'h000, {1'b0, regQ});
			aLoad <= 1'b0;
			clrOne <= 1'b0;
			w(8);
		end
	endtask
	task test_shift;
		begin
			pulse(1'b1);
			pulse(1'b0);
			pulse(1'b1);
			chk(11'h005, {1'b0, regQ});
			enaOne <= 1'b0;
			w(6);
			pulse(1'b1);
			chk(11'h005, {1'b0, regQ});
			enaOne <= 1'b1;
		end
	endtask
	// Sync load then sync clear; chain tail must follow the last register
	task test_sync;
		begin
			sData <= 10'h3aa;
			sLoad <= 1'b1;
			pulse(1'b0);
			chk(11'h7aa, {chainOut, regQ});
			sLoad <= 1'b0;
			sClr <= 1'b1;
			pulse(1'b0);
			chk(11'h000, {chainOut, regQ});
			sClr <= 1'b0;
		end
	endtask
	// Subtract must add the inverted operand plus a forced carry-in
	task test_arith;
		begin
			arith <= 1'b1;
			w(8);
			chk({1'b0, opA} + {1'b0, opB}, {carry, lutQ});
			addSub <= 1'b1;
			w(8);
			chk({1'b0, opA} + {1'b0, ~opB} + 11'h001, {carry, lutQ});
		end
	endtask
	task complete_run;
		begin
			if (errCount == 0 && samplesChecked > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	initial begin
		w(10);
		rst_n <= 1'b1;
		w(6);
		test_preset;
		test_shift;
		test_sync;
		test_arith;
		complete_run;
	end
	// Run needs about 134 cycles; far beyond that means a hang
	initial begin
		#50000;
		errCount = errCount + 1;
		complete_run;
	end
endmodule
`default_nettype wire
